//--- src/mal_limit_cmd.sv
`timescale 1ns/1ps
module mal_limit_cmd #(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_1000_0000, // native max lba
  parameter logic [7:0]  HEADS      = 8'h10, // heads in chs geometry
  parameter bit          LBA48_EN   = 1'b1   // 48-bit addressing present
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        offset_mode_i, // address offset mode active
  input  wire logic        hpa_ext_i,     // area set by extended form
  input  wire logic        nv_valid_i,    // saved limit exists
  input  wire logic [47:0] nv_limit_i,    // saved limit from media
  output logic             nv_wr_o,       // pulse: save limit now
  output logic [47:0]      nv_limit_o,    // limit to save
  input  wire logic        acc_req_i,     // media access request
  input  wire logic [47:0] acc_lba_i,     // its address
  output logic             acc_abort_o,   // access lies above limit
  output logic [31:0]      id_w61_60_o,   // identify words 61:60
  output logic [63:0]      id_w103_100_o  // identify words 103:100
);
  // whole block state
  typedef struct packed {
    mal_pkg::mal_phase_type phase;
    logic [7:0]  fea, sc, sn, cl, ch, dh; // command block registers
    logic [7:0]  err, stat;               // error and status
    logic        prior_rnm;  // last command was read native max
    logic        nv_used;    // nonvolatile setting already accepted
    logic        locked;     // protection locked
    logic        frozen;     // protection frozen
    logic [2:0]  tries;      // unlock attempts left
    logic        unl;        // data sector belongs to unlock
    logic [7:0]  widx;       // data word index
    logic [47:0] max_lba;    // current limit
    logic [27:0] rep28;      // value shown in words 61:60
    logic        nv_wr;      // save pulse
    logic [31:0] rdata;      // captured read data
    logic        slverr;     // captured decode error
  } mal_state_type;

  localparam mal_state_type RST_STATE = '{
    phase: mal_pkg::MAL_BOOT, stat: mal_pkg::STAT_RST,
    tries: mal_pkg::UNLOCK_TRIES, default: '0};

  mal_state_type          r_reg;
  mal_state_type          r_next;
  mal_pkg::mal_pw_req_type pw_req;  // word towards password store
  logic                   pw_match; // sector matched stored password
  logic                   wr_acc;   // apb write access phase
  logic                   lba_mode; // device/head selects lba
  logic                   nv_opt;   // persistence option
  logic [15:0]            cyl;      // requested cylinder
  logic [47:0]            req_lba;  // requested limit as lba
  logic                   set_bad;  // limit setting must abort

  // words 61:60 never exceed the 28-bit range
  function automatic logic [27:0] rep_of(input logic [47:0] m);
    rep_of = (m > mal_pkg::LBA28_MAX) ? 28'hFFF_FFFF : m[27:0];
  endfunction

  // read mux for the setup phase
  function automatic logic [32:0] rd_of(input mal_state_type s,
                                        input logic [7:0] a);
    logic [47:0] m48;
    m48 = LBA48_EN ? s.max_lba : 48'h0;
    case (a)
      mal_pkg::OFS_DATA:    rd_of = {1'b0, 32'h0};
      mal_pkg::OFS_FEAT:    rd_of = {1'b0, 24'h0, s.err};
      mal_pkg::OFS_SECCNT:  rd_of = {1'b0, 24'h0, s.sc};
      mal_pkg::OFS_SECNUM:  rd_of = {1'b0, 24'h0, s.sn};
      mal_pkg::OFS_CYLLO:   rd_of = {1'b0, 24'h0, s.cl};
      mal_pkg::OFS_CYLHI:   rd_of = {1'b0, 24'h0, s.ch};
      mal_pkg::OFS_DEVHEAD: rd_of = {1'b0, 24'h0, s.dh};
      mal_pkg::OFS_CMD:     rd_of = {1'b0, 24'h0, s.stat};
      mal_pkg::OFS_ID28:    rd_of = {1'b0, 4'h0, s.rep28};
      mal_pkg::OFS_ID48LO:  rd_of = {1'b0, m48[31:0]};
      mal_pkg::OFS_ID48HI:  rd_of = {1'b0, 16'h0, m48[47:32]};
      mal_pkg::OFS_PROT:    rd_of = {1'b0, 24'h0, s.tries, s.nv_used,
                                     s.prior_rnm, s.unl, s.frozen,
                                     s.locked};
      default:              rd_of = {1'b1, 32'h0};
    endcase
  endfunction

  // decode of the requested limit
  always_comb begin
    lba_mode = r_reg.dh[mal_pkg::DH_LBA];
    nv_opt   = r_reg.sc[mal_pkg::SC_NV];
    cyl      = {r_reg.ch, r_reg.cl};
    if (lba_mode) begin
      req_lba = {20'h0, r_reg.dh[3:0], r_reg.ch, r_reg.cl,
                 r_reg.sn};
    end else begin
      // last sector of the requested cylinder; sector and head ignored
      req_lba = 48'(((32'(cyl) + 32'h1) * 32'(HEADS) *
                     32'(mal_pkg::CHS_SECTORS)) - 32'h1);
    end
    set_bad = r_reg.locked || r_reg.frozen ||
              hpa_ext_i ||
              (nv_opt && r_reg.nv_used) ||
              (nv_opt && offset_mode_i) ||
              (req_lba > NATIVE_MAX);
  end

  // next state: bus, command execution and data sector
  always_comb begin
    r_next       = r_reg;
    r_next.nv_wr = 1'b0;
    pw_req       = '0;
    wr_acc       = psel_i && penable_i && pwrite_i;
    if (psel_i && !penable_i) begin
      {r_next.slverr, r_next.rdata} = rd_of(r_reg, paddr_i);
    end
    case (r_reg.phase)
      mal_pkg::MAL_BOOT: begin
        // volatile limit is gone, a saved one comes back
        r_next.max_lba = nv_valid_i ? nv_limit_i : NATIVE_MAX;
        r_next.rep28   = rep_of(r_next.max_lba);
        r_next.stat    = mal_pkg::STAT_READY;
        r_next.phase   = mal_pkg::MAL_IDLE;
      end
      mal_pkg::MAL_IDLE: begin
        if (wr_acc) begin
          case (paddr_i)
            mal_pkg::OFS_FEAT:    r_next.fea = pwdata_i[7:0];
            mal_pkg::OFS_SECCNT:  r_next.sc  = pwdata_i[7:0];
            mal_pkg::OFS_SECNUM:  r_next.sn  = pwdata_i[7:0];
            mal_pkg::OFS_CYLLO:   r_next.cl  = pwdata_i[7:0];
            mal_pkg::OFS_CYLHI:   r_next.ch  = pwdata_i[7:0];
            mal_pkg::OFS_DEVHEAD: r_next.dh  = pwdata_i[7:0];
            mal_pkg::OFS_CMD: begin
              // every command ends the read-native-max pairing
              r_next.prior_rnm = 1'b0;
              r_next.err       = 8'h00;
              r_next.stat      = mal_pkg::STAT_READY;
              if (pwdata_i[7:0] == mal_pkg::CMD_RD_NATIVE) begin
                r_next.prior_rnm = 1'b1;
                r_next.sn = NATIVE_MAX[7:0];
                r_next.cl = NATIVE_MAX[15:8];
                r_next.ch = NATIVE_MAX[23:16];
                r_next.dh = {r_reg.dh[7:4], NATIVE_MAX[27:24]};
              end else if (pwdata_i[7:0] != mal_pkg::CMD_SET_MAX) begin
                r_next.err  = mal_pkg::ERR_ABORT;
                r_next.stat = mal_pkg::STAT_ABORT;
              end else if (r_reg.prior_rnm) begin
                if (set_bad) begin
                  // limit untouched, only flags change
                  r_next.err  = mal_pkg::ERR_ABORT;
                  r_next.stat = mal_pkg::STAT_ABORT;
                end else begin
                  if (lba_mode && req_lba == mal_pkg::LBA28_MAX &&
                      NATIVE_MAX > mal_pkg::LBA28_MAX) begin
                    r_next.max_lba = NATIVE_MAX;
                  end else begin
                    r_next.max_lba = req_lba;
                  end
                  r_next.rep28 = rep_of(r_next.max_lba);
                  if (nv_opt) begin
                    r_next.nv_used = 1'b1;
                    r_next.nv_wr   = 1'b1;
                  end
                  if (lba_mode) begin
                    r_next.sn = req_lba[7:0];
                    r_next.dh = {r_reg.dh[7:4], req_lba[27:24]};
                  end else begin
                    r_next.sn = mal_pkg::CHS_SECTORS;
                    r_next.dh = {r_reg.dh[7:4], 4'(HEADS - 8'h1)};
                  end
                end
              end else begin
                // extension subcommands picked by feature
                case (r_reg.fea)
                  mal_pkg::FEAT_SET_PW: begin
                    if (!r_reg.locked && !r_reg.frozen) begin
                      r_next.unl = 1'b0;
                      r_next.phase = mal_pkg::MAL_DATA;
                    end
                  end
                  mal_pkg::FEAT_LOCK: begin
                    if (!r_reg.locked && !r_reg.frozen) begin
                      r_next.locked = 1'b1;
                    end
                  end
                  mal_pkg::FEAT_UNLOCK: begin
                    if (!r_reg.frozen && r_reg.tries != 3'h0) begin
                      r_next.unl = 1'b1;
                      r_next.phase = mal_pkg::MAL_DATA;
                    end
                  end
                  mal_pkg::FEAT_FREEZE: begin
                    if (!r_reg.frozen) begin
                      r_next.frozen = 1'b1;
                      r_next.locked = 1'b0;
                    end
                  end
                  default: ;
                endcase
                // anything not taken above is refused
                if (r_next.phase == mal_pkg::MAL_DATA) begin
                  r_next.stat  = mal_pkg::STAT_DRQ;
                  r_next.widx  = 8'h00;
                  pw_req.start = 1'b1;
                end else if (r_next.locked == r_reg.locked &&
                             r_next.frozen == r_reg.frozen) begin
                  r_next.err  = mal_pkg::ERR_ABORT;
                  r_next.stat = mal_pkg::STAT_ABORT;
                end
              end
            end
            default: ;
          endcase
        end
      end
      mal_pkg::MAL_DATA: begin
        // only data words are taken while a sector is due
        if (wr_acc && paddr_i == mal_pkg::OFS_DATA) begin
          pw_req.wr   = 1'b1;
          pw_req.cmp  = r_reg.unl;
          pw_req.idx  = r_reg.widx;
          pw_req.data = pwdata_i[15:0];
          r_next.widx = r_reg.widx + 8'h01;
          if (r_reg.widx == mal_pkg::SECTOR_LAST) begin
            r_next.phase = mal_pkg::MAL_IDLE;
            r_next.stat  = mal_pkg::STAT_READY;
            if (!r_reg.unl || pw_match) begin
              r_next.locked = 1'b0;
            end else begin
              r_next.tries = r_reg.tries - 3'h1;
              r_next.err   = mal_pkg::ERR_ABORT;
              r_next.stat  = mal_pkg::STAT_ABORT;
            end
          end
        end
      end
      default: r_next.phase = mal_pkg::MAL_BOOT;
    endcase
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  mal_pw_store u_pw (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (pw_req),
    .match_o (pw_match)
  );

  // zero wait state: read data was captured in the setup phase
  assign pready_o      = 1'b1;
  assign prdata_o      = r_reg.rdata;
  assign pslverr_o     = psel_i && penable_i && r_reg.slverr;
  assign nv_wr_o       = r_reg.nv_wr;
  assign nv_limit_o    = r_reg.max_lba;
  assign acc_abort_o   = acc_req_i && (acc_lba_i > r_reg.max_lba);
  assign id_w61_60_o   = {4'h0, r_reg.rep28};
  assign id_w103_100_o = LBA48_EN ? {16'h0, r_reg.max_lba} : 64'h0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_abort_flags: assert property (r_reg.stat[mal_pkg::ST_ERR] |->
    r_reg.err[mal_pkg::ER_ABT] && !r_reg.stat[mal_pkg::ST_BSY])
    else $error("error status without abort flag");
  a_frozen_limit: assert property (r_reg.frozen |=>
    r_reg.frozen && $stable(r_reg.max_lba))
    else $error("limit moved while frozen");
  a_limit_cap: assert property (r_reg.phase != mal_pkg::MAL_BOOT |->
    r_reg.max_lba <= NATIVE_MAX)
    else $error("limit above native capacity");
  a_id_small: assert property (r_reg.max_lba <= mal_pkg::LBA28_MAX |->
    id_w61_60_o == r_reg.max_lba[31:0])
    else $error("identify words disagree");
  a_id_large: assert property (r_reg.max_lba > mal_pkg::LBA28_MAX |->
    r_reg.rep28 == 28'hFFF_FFFF)
    else $error("large limit not clipped in 28-bit words");
  a_tries_zero: assert property (r_reg.tries == 3'h0 |=>
    r_reg.tries == 3'h0 && r_reg.phase != mal_pkg::MAL_DATA)
    else $error("unlock accepted with no tries left");
  a_nv_once: assert property (r_reg.nv_used |=> !r_reg.nv_wr)
    else $error("second nonvolatile setting accepted");
  a_prior_drop: assert property (wr_acc && paddr_i == mal_pkg::OFS_CMD &&
    r_reg.phase == mal_pkg::MAL_IDLE &&
    pwdata_i[7:0] != mal_pkg::CMD_RD_NATIVE |=> !r_reg.prior_rnm)
    else $error("pairing survived another command");
  a_data_drq: assert property (r_reg.phase == mal_pkg::MAL_DATA |->
    r_reg.stat == mal_pkg::STAT_DRQ)
    else $error("data phase without request flag");

  c_set_ok: cover property (r_reg.prior_rnm &&
    r_next.max_lba != r_reg.max_lba);
  c_lock: cover property ($rose(r_reg.locked));
  c_bad_pw: cover property ($fell(r_reg.tries[0]));
  c_freeze: cover property ($rose(r_reg.frozen));
endmodule

//--- src/mal_pkg.sv
package mal_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_DATA    = 8'h00; // data port, 16-bit words
  localparam logic [7:0] OFS_FEAT    = 8'h04; // write feature, read error
  localparam logic [7:0] OFS_SECCNT  = 8'h08; // sector count
  localparam logic [7:0] OFS_SECNUM  = 8'h0C; // sector number
  localparam logic [7:0] OFS_CYLLO   = 8'h10; // cylinder low
  localparam logic [7:0] OFS_CYLHI   = 8'h14; // cylinder high
  localparam logic [7:0] OFS_DEVHEAD = 8'h18; // device/head
  localparam logic [7:0] OFS_CMD     = 8'h1C; // write command, read status
  localparam logic [7:0] OFS_ID28    = 8'h20; // identify words 61:60
  localparam logic [7:0] OFS_ID48LO  = 8'h24; // identify words 101:100
  localparam logic [7:0] OFS_ID48HI  = 8'h28; // identify words 103:102
  localparam logic [7:0] OFS_PROT    = 8'h2C; // protection state
  // opcodes and extension subcommands
  localparam logic [7:0] CMD_SET_MAX   = 8'hF9;
  localparam logic [7:0] CMD_RD_NATIVE = 8'hF8;
  localparam logic [7:0] FEAT_SET_PW   = 8'h01;
  localparam logic [7:0] FEAT_LOCK     = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK   = 8'h03;
  localparam logic [7:0] FEAT_FREEZE   = 8'h04;
  // status, error and parameter bit positions
  localparam int unsigned ST_BSY  = 7;
  localparam int unsigned ST_RDY  = 6;
  localparam int unsigned ST_DRQ  = 3;
  localparam int unsigned ST_ERR  = 0;
  localparam int unsigned ER_ABT  = 2;
  localparam int unsigned SC_NV   = 0; // persistence option in sector count
  localparam int unsigned DH_LBA  = 6; // addressing mode in device/head
  // reset values and fixed figures
  localparam logic [7:0]  STAT_RST    = 8'h00;
  localparam logic [7:0]  STAT_READY  = 8'h40;
  localparam logic [7:0]  STAT_DRQ    = 8'h48;
  localparam logic [7:0]  STAT_ABORT  = 8'h41;
  localparam logic [7:0]  ERR_ABORT   = 8'h04;
  localparam logic [47:0] LBA28_MAX   = 48'h0000_0FFF_FFFF;
  localparam logic [7:0]  CHS_SECTORS = 8'h3F;
  localparam logic [2:0]  UNLOCK_TRIES = 3'h5;
  localparam logic [7:0]  SECTOR_LAST = 8'hFF; // last word of a sector
  localparam logic [7:0]  PW_FIRST    = 8'h01; // first password word
  localparam int unsigned PW_WORDS    = 16;

  // command phases, one-hot
  typedef enum logic [2:0] {
    MAL_BOOT = 3'b001,
    MAL_IDLE = 3'b010,
    MAL_DATA = 3'b100
  } mal_phase_type;

  // one data word towards the password store
  typedef struct packed {
    logic        start; // new sector begins
    logic        cmp;   // compare instead of store
    logic        wr;    // word valid
    logic [7:0]  idx;   // word index in sector
    logic [15:0] data;  // word value
  } mal_pw_req_type;
endpackage

//--- src/mal_pw_store.sv
`timescale 1ns/1ps
module mal_pw_store (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire mal_pkg::mal_pw_req_type req_i,
  output logic                         match_o
);
  // stored password and the running mismatch flag
  typedef struct packed {
    logic [mal_pkg::PW_WORDS-1:0][15:0] pw;
    logic                               mism;
  } mal_pws_type;

  mal_pws_type                 s_reg;
  mal_pws_type                 s_next;
  logic [mal_pkg::PW_WORDS-1:0] hit; // word lands in this slot

  // slot decode; reserved words miss every slot
  for (genvar g = 0; g < mal_pkg::PW_WORDS; g++) begin : g_slot
    assign hit[g] = req_i.wr &&
      (req_i.idx == mal_pkg::PW_FIRST + 8'(g));
  end

  // store on set, compare on unlock
  always_comb begin
    s_next = s_reg;
    if (req_i.start) begin
      s_next.mism = 1'b0;
    end
    for (int i = 0; i < mal_pkg::PW_WORDS; i++) begin
      if (hit[i] && req_i.cmp) begin
        if (s_reg.pw[i] != req_i.data) begin
          s_next.mism = 1'b1;
        end
      end else if (hit[i]) begin
        s_next.pw[i] = req_i.data;
      end
    end
  end

  // password survives everything but reset, i.e. a power cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign match_o = ~s_reg.mism;

  a_store_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_i.wr |=> $stable(s_reg.pw))
    else $error("password changed without a data word");
endmodule

//--- test/mal_host_model.sv
`timescale 1ns/1ps
// host adapter model: apb master facing the command block registers
module mal_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  logic [31:0] dat_q; // read data taken at the ending edge
  logic        err_q; // error answer taken at the ending edge
  // bus idle at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'hFF;
    pwdata_o = 32'h0;
  end
  // the answer is caught on the edge itself, so slave flops cannot race it
  always_ff @(posedge clk_i) begin
    if (psel_o && penable_o && pready_i) begin
      dat_q <= prdata_i;
      err_q <= pslverr_i;
    end
  end
  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released address and data lines carry the inverse, never the last value
    paddr_o <= ~a;
    pwdata_o <= ~d;
    @(negedge clk_i);
    r = dat_q;
    e = err_q;
  endtask
  // plain register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask
  // lba limit packed over four registers, persistence in sector count
  task automatic set_lba(input logic [27:0] v, input logic b);
    wr(mal_pkg::OFS_SECCNT, {31'h0, b});
    wr(mal_pkg::OFS_SECNUM, {24'h0, v[7:0]});
    wr(mal_pkg::OFS_CYLLO, {24'h0, v[15:8]});
    wr(mal_pkg::OFS_CYLHI, {24'h0, v[23:16]});
    wr(mal_pkg::OFS_DEVHEAD, {24'h0, 4'hE, v[27:24]});
  endtask
  // one whole sector; password in words 1..16, reserved words filler
  task automatic send_sector(input logic [15:0] pw, input logic [15:0] rs);
    for (int i = 0; i < 256; i++) begin
      if (i >= 1 && i <= 16)
        wr(mal_pkg::OFS_DATA, {16'h0, pw ^ 16'(i)});
      else wr(mal_pkg::OFS_DATA, {16'h0, rs});
    end
  endtask
endmodule

//--- test/mal_limit_cmd_tb.sv
`timescale 1ns/1ps
// self-checking bench for the max address limit command block
module mal_limit_cmd_tb;
  localparam logic [47:0] NATIVE = 48'h0000_1000_0000; // above 28 bits
  logic        clk_i = 1'b0;               // 25 MHz
  logic        rst_i = 1'b1;               // held at start
  logic        psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rv;
  logic        pready_o, pslverr_o, e;
  logic        offset_mode_i = 1'b0, hpa_ext_i = 1'b0;
  logic        nv_valid_i = 1'b0, acc_req_i = 1'b0;
  logic [47:0] nv_limit_i = 48'h0, acc_lba_i = 48'h0, nv_limit_o;
  logic        nv_wr_o, acc_abort_o;
  logic [31:0] id_w61_60_o;
  logic [63:0] id_w103_100_o;
  int          fail_count = 0, compares = 0, nv_pulses = 0;
  always #20 clk_i = ~clk_i;
  mal_limit_cmd #(.NATIVE_MAX(NATIVE), .HEADS(8'h10), .LBA48_EN(1'b1)) dut (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .offset_mode_i, .hpa_ext_i,
    .nv_valid_i, .nv_limit_i, .nv_wr_o, .nv_limit_o, .acc_req_i,
    .acc_lba_i, .acc_abort_o, .id_w61_60_o, .id_w103_100_o);
  mal_host_model host (.clk_i, .prdata_i(prdata_o), .pready_i(pready_o),
    .pslverr_i(pslverr_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  // count save pulses; one per accepted nonvolatile setting
  always @(posedge clk_i) if (nv_wr_o === 1'b1) nv_pulses <= nv_pulses + 1;
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] ft);
    host.wr(mal_pkg::OFS_FEAT, {24'h0, ft});
    host.wr(mal_pkg::OFS_CMD, {24'h0, op});
  endtask
  // status, and error flags that follow from it
  task automatic stat(input logic [7:0] s);
    rd(mal_pkg::OFS_CMD, rv);
    chk("status", {24'h0, s}, rv);
    rd(mal_pkg::OFS_FEAT, rv);
    chk("error", (s == mal_pkg::STAT_ABORT) ? 32'h4 : 32'h0, rv);
  endtask
  // read-native first, then the setting itself
  task automatic set_max(input logic [27:0] v, input logic b,
                         input logic [7:0] s);
    host.wr(mal_pkg::OFS_CMD, {24'h0, mal_pkg::CMD_RD_NATIVE});
    host.set_lba(v, b);
    host.wr(mal_pkg::OFS_CMD, {24'h0, mal_pkg::CMD_SET_MAX});
    stat(s);
  endtask
  task automatic id_chk(input logic [47:0] lim);
    chk("id28", {4'h0, lim[27:0]}, id_w61_60_o);
    chk("id48", lim[31:0], id_w103_100_o[31:0]);
    chk("id48 hi", {16'h0, lim[47:32]}, id_w103_100_o[63:32]);
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_boot;
    stat(mal_pkg::STAT_READY);
    chk("native", NATIVE[31:0], id_w103_100_o[31:0]);
    rd(8'h30, rv);
    chk("unmapped", 32'h1, {31'h0, e});
    cmd(mal_pkg::CMD_SET_MAX, 8'h05);
    stat(mal_pkg::STAT_ABORT);
    $display("test boot done");
  endtask
  task automatic t_lba;
    set_max(28'h0001234, 1'b0, mal_pkg::STAT_READY);
    rd(mal_pkg::OFS_SECNUM, rv);
    chk("ret sn", 32'h34, rv);
    rd(mal_pkg::OFS_CYLLO, rv);
    chk("ret cl", 32'h12, rv);
    id_chk(48'h1234);
    @(posedge clk_i);
    acc_req_i <= 1'b1;
    acc_lba_i <= 48'h1235;
    @(negedge clk_i);
    chk("above", 32'h1, {31'h0, acc_abort_o});
    @(posedge clk_i);
    acc_lba_i <= 48'h1234;
    @(negedge clk_i);
    chk("at limit", 32'h0, {31'h0, acc_abort_o});
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    acc_lba_i <= 48'h2000;
    @(negedge clk_i);
    chk("no request", 32'h0, {31'h0, acc_abort_o});
    cmd(mal_pkg::CMD_SET_MAX, 8'h00);
    stat(mal_pkg::STAT_ABORT);
    id_chk(48'h1234);
    set_max(28'hFFFFFFF, 1'b0, mal_pkg::STAT_READY);
    chk("id28 max", 32'h0FFFFFFF, id_w61_60_o);
    chk("id48 native", NATIVE[31:0], id_w103_100_o[31:0]);
    rd(mal_pkg::OFS_ID28, rv);
    chk("reg id28", 32'h0FFFFFFF, rv);
    rd(mal_pkg::OFS_ID48LO, rv);
    chk("reg id48", NATIVE[31:0], rv);
    $display("test lba done");
  endtask
  task automatic t_chs;
    host.wr(mal_pkg::OFS_CMD, {24'h0, mal_pkg::CMD_RD_NATIVE});
    host.wr(mal_pkg::OFS_SECNUM, 32'hAA);
    host.wr(mal_pkg::OFS_CYLLO, 32'h02);
    host.wr(mal_pkg::OFS_CYLHI, 32'h00);
    host.wr(mal_pkg::OFS_DEVHEAD, 32'hA5);
    host.wr(mal_pkg::OFS_CMD, {24'h0, mal_pkg::CMD_SET_MAX});
    stat(mal_pkg::STAT_READY);
    id_chk(48'hBCF);
    rd(mal_pkg::OFS_SECNUM, rv);
    chk("chs sn", 32'h3F, rv);
    rd(mal_pkg::OFS_DEVHEAD, rv);
    chk("chs head", 32'hF, {28'h0, rv[3:0]});
    $display("test chs done");
  endtask
  task automatic t_nv;
    @(posedge clk_i);
    hpa_ext_i <= 1'b1;
    set_max(28'h500, 1'b0, mal_pkg::STAT_ABORT);
    @(posedge clk_i);
    hpa_ext_i <= 1'b0;
    offset_mode_i <= 1'b1;
    set_max(28'h500, 1'b1, mal_pkg::STAT_ABORT);
    @(posedge clk_i);
    offset_mode_i <= 1'b0;
    id_chk(48'hBCF);
    set_max(28'h600, 1'b1, mal_pkg::STAT_READY);
    chk("saves", 32'd1, nv_pulses);
    chk("saved", 32'h600, nv_limit_o[31:0]);
    set_max(28'h700, 1'b1, mal_pkg::STAT_ABORT);
    chk("no save", 32'd1, nv_pulses);
    $display("test nonvolatile done");
  endtask
  task automatic t_pw;
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_SET_PW);
    stat(mal_pkg::STAT_DRQ);
    host.send_sector(16'hA000, 16'h1111);
    stat(mal_pkg::STAT_READY);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_LOCK);
    stat(mal_pkg::STAT_READY);
    set_max(28'h800, 1'b0, mal_pkg::STAT_ABORT);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_SET_PW);
    stat(mal_pkg::STAT_ABORT);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_UNLOCK);
    host.send_sector(16'hB000, 16'h1111);
    stat(mal_pkg::STAT_ABORT);
    rd(mal_pkg::OFS_PROT, rv);
    chk("tries", 32'h4, {29'h0, rv[7:5]});
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_UNLOCK);
    host.send_sector(16'hA000, 16'h2222);
    stat(mal_pkg::STAT_READY);
    set_max(28'h800, 1'b0, mal_pkg::STAT_READY);
    // use up the remaining tries, then unlock must be refused at once
    for (int k = 0; k < 4; k++) begin
      cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_UNLOCK);
      host.send_sector(16'hC000, 16'h1111);
    end
    rd(mal_pkg::OFS_PROT, rv);
    chk("no tries", 32'h0, {29'h0, rv[7:5]});
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_UNLOCK);
    stat(mal_pkg::STAT_ABORT);
    $display("test password done");
  endtask
  task automatic t_freeze;
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_FREEZE);
    stat(mal_pkg::STAT_READY);
    set_max(28'h900, 1'b0, mal_pkg::STAT_ABORT);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_SET_PW);
    stat(mal_pkg::STAT_ABORT);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_LOCK);
    stat(mal_pkg::STAT_ABORT);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_UNLOCK);
    stat(mal_pkg::STAT_ABORT);
    cmd(mal_pkg::CMD_SET_MAX, mal_pkg::FEAT_FREEZE);
    stat(mal_pkg::STAT_ABORT);
    $display("test freeze done");
  endtask
  // read-native just before reset must be forgotten
  task automatic t_reset;
    host.wr(mal_pkg::OFS_CMD, {24'h0, mal_pkg::CMD_RD_NATIVE});
    @(posedge clk_i);
    nv_valid_i <= 1'b1;
    nv_limit_i <= 48'h650;
    do_reset();
    id_chk(48'h650);
    rd(mal_pkg::OFS_PROT, rv);
    chk("prot", 32'hA0, rv);
    cmd(mal_pkg::CMD_SET_MAX, 8'h00);
    stat(mal_pkg::STAT_ABORT);
    set_max(28'h660, 1'b1, mal_pkg::STAT_READY);
    chk("saves", 32'd2, nv_pulses);
    $display("test reset done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_boot();
    t_lba();
    t_chs();
    t_nv();
    t_pw();
    t_freeze();
    t_reset();
    test_done();
  end
  // watchdog: whole run needs some 6000 cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
endmodule
